// ---- prs_row_mirror_lut.sv ----
// Row skipping, mirroring and luminance substitution of a pixel stream
`include "prs_consts.svh"
// What this block does
// R01: Skip factor n forwards every nth row
// R02: Kept rows are 0, n, 2n, ...
// R03: Height becomes ceil(height/n), rounded up even
// R04: Colour sensor, factor two: rows in pairs
// R05: Vertical binning and skipping exclude each other
// R06: Enabling skip shrinks window height
// R07: Factor one never restores window height
// R08: Horizontal mirror reverses pixels in line
// R09: Vertical mirror reverses lines in frame
// R10: Both mirrors may act together
// R11: Measurement windows stay in sensor order
// R12: Software sets mirror enables to one
// R13: Table of 4096 twelve-bit entries substitutes
// R14: Table off, 12-bit format: raw pass
// R15: Only multiple-of-eight entries used directly
// R16: Between entries: straight-line interpolation
// R17: Weights 8-f and f, divide, truncate
// R18: Above 4088 use entry 4088 only
// R19: Ten-bit sensor gets two zero LSBs
// R20: One table for all colours
// R21: Table lost at reset; software reloads
// R22: Ten-bit format drops two LSBs
// R23: Eight-bit format drops four LSBs
// R24: Software enables table after filling
module prs_row_mirror_lut #(
	parameter int MAX_W = 64,
	parameter int MAX_H = 64
) (
	input wire logic core_clk,
	input wire logic srst,
	input prs_pkg::prs_pix_t pin,
	output logic in_ready,
	output prs_pkg::prs_pix_t pout,
	input prs_pkg::prs_breq_t breq,
	output logic [31:0] rdata
);
	import prs_pkg::*;

	localparam int AW = $clog2(MAX_W * MAX_H);
	localparam logic [15:0] MW = 16'(MAX_W);
	localparam logic [15:0] MH = 16'(MAX_H);

	generate
		if (MAX_W < 2 || MAX_H < 2 || MAX_W > 4096 || MAX_H > 4096) begin : g_bad
			$error("prs_row_mirror_lut: frame store size out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	prs_state_t s_ff;
	prs_state_t nxt_s;
	logic [11:0] tbl_ff [0:4095];
	logic [11:0] fbuf_ff [0:MAX_W*MAX_H-1];

	// ----------------------------------------------------------------
	// Input side
	// ----------------------------------------------------------------
	logic acc;
	logic keep;
	logic [15:0] cr;
	logic [15:0] cc;
	logic [15:0] ck;
	logic [7:0] cp;
	logic [15:0] cfw;
	logic [15:0] cfh;
	logic [11:0] din;
	logic wen;
	logic [AW-1:0] waddr;

	always_comb begin
		acc = pin.vld && s_ff.rdy &&
			(s_ff.st == PRS_FILL || pin.sof);
		cr = pin.sof ? 16'h0000 : s_ff.row;
		cc = pin.sof ? 16'h0000 : s_ff.col;
		ck = pin.sof ? 16'h0000 : s_ff.krow;
		cp = pin.sof ? 8'h00 : s_ff.ph;
		cfw = s_ff.fw;
		cfh = s_ff.fh;
		if (pin.sof) begin
			cfw = (s_ff.winw < MW) ? s_ff.winw : MW;
			cfh = (s_ff.winh < MH) ? s_ff.winh : MH;
		end
		if (s_ff.colr && s_ff.skip == `PRS_FAC_TWO) begin
			keep = ~cr[1]; // see R04
		end else begin
			keep = (cp == 8'h00); // see R01 see R02
		end
		din = s_ff.s10 ? {pin.data[9:0], 2'b00} : pin.data; // see R19
		wen = acc && keep && cc < cfw && ck < cfh;
		// Stored in sensor order; measurement windows see no mirror
		waddr = AW'(32'(ck) * MAX_W + 32'(cc)); // see R11
	end

	// ----------------------------------------------------------------
	// Output side
	// ----------------------------------------------------------------
	logic [15:0] rr;
	logic [15:0] rc;
	logic [AW-1:0] raddr;
	logic [11:0] x;
	logic [11:0] lo_i;
	logic [11:0] hi_i;
	logic top;
	logic [11:0] lo;
	logic [11:0] hi;
	logic [3:0] fr;
	logic [15:0] sum;
	logic [11:0] sub;
	logic [11:0] y;
	logic [11:0] od;

	always_comb begin
		rr = s_ff.vmir ? s_ff.fh - 16'h0001 - s_ff.orow : s_ff.orow; // see R09
		rc = s_ff.hmir ? s_ff.fw - 16'h0001 - s_ff.ocol : s_ff.ocol; // see R08
		// Both reversals share one address, so they combine freely
		raddr = AW'(32'(rr) * MAX_W + 32'(rc)); // see R10
		x = s_ff.p1.data;
		top = x >= `PRS_TLAST; // see R18
		lo_i = top ? `PRS_TLAST : {x[11:3], 3'b000}; // see R15
		hi_i = top ? `PRS_TLAST : lo_i + `PRS_TSTEP;
		lo = tbl_ff[lo_i]; // see R20
		hi = tbl_ff[hi_i];
		fr = {1'b0, x[2:0]};
		sum = 16'(lo) * 16'(`PRS_WGT_FULL - fr)
			+ 16'(hi) * 16'(fr); // see R16 see R17
		// Aligned pixel never touches the upper entry, loaded or not
		sub = (top || fr == 4'h0) ? lo : sum[14:3]; // see R15 see R17
		y = s_ff.ten ? sub : x; // see R13 see R14
		case (s_ff.fmt)
			PRS_FMT10: od = {2'b00, y[11:2]}; // see R22
			PRS_FMT8: od = {4'h0, y[11:4]}; // see R23
			default: od = y;
		endcase
	end

	// ----------------------------------------------------------------
	// Register side effects
	// ----------------------------------------------------------------
	logic [7:0] wfac;
	logic [15:0] qh;

	always_comb begin
		wfac = (breq.wdata[7:0] == 8'h00) ? `PRS_FAC_ONE : breq.wdata[7:0];
		qh = (s_ff.winh + 16'(wfac) - 16'h0001) / 16'(wfac); // see R03
		if (qh[0]) begin
			qh = qh + 16'h0001; // see R03
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.rdat = 32'h0000_0000;
		nxt_s.out = '0;
		nxt_s.p1 = '0;
		if (breq.wr) begin
			case (breq.addr)
				`PRS_A_CTRL: begin
					nxt_s.hmir = breq.wdata[`PRS_B_HMIR]; // see R12
					nxt_s.vmir = breq.wdata[`PRS_B_VMIR]; // see R12
					nxt_s.ten = breq.wdata[`PRS_B_TEN]; // see R24
					nxt_s.colr = breq.wdata[`PRS_B_COLR];
					nxt_s.s10 = breq.wdata[`PRS_B_S10];
					nxt_s.fmt = prs_fmt_t'(breq.wdata[`PRS_F_FMT]);
				end
				`PRS_A_SKIP: begin
					nxt_s.skip = wfac;
					if (wfac != `PRS_FAC_ONE) begin
						nxt_s.vbin = `PRS_FAC_ONE; // see R05
						nxt_s.winh = qh; // see R06
					end
					// Factor one leaves the height as it is; see R07
				end
				`PRS_A_VBIN: begin
					nxt_s.vbin = wfac;
					if (wfac != `PRS_FAC_ONE) begin
						nxt_s.skip = `PRS_FAC_ONE; // see R05
					end
				end
				`PRS_A_HBIN: nxt_s.hbin = wfac;
				`PRS_A_WINW: nxt_s.winw = breq.wdata[15:0];
				`PRS_A_WINH: nxt_s.winh = breq.wdata[15:0]; // see R07
				`PRS_A_TIDX: nxt_s.tidx = breq.wdata[11:0];
				default: ;
			endcase
		end
		if (breq.rd) begin
			case (breq.addr)
				`PRS_A_CTRL: nxt_s.rdat = {25'h0, s_ff.fmt, s_ff.s10,
					s_ff.colr, s_ff.ten, s_ff.vmir, s_ff.hmir};
				`PRS_A_SKIP: nxt_s.rdat = {24'h0, s_ff.skip};
				`PRS_A_VBIN: nxt_s.rdat = {24'h0, s_ff.vbin};
				`PRS_A_HBIN: nxt_s.rdat = {24'h0, s_ff.hbin};
				`PRS_A_WINW: nxt_s.rdat = {16'h0, s_ff.winw};
				`PRS_A_WINH: nxt_s.rdat = {16'h0, s_ff.winh};
				`PRS_A_TIDX: nxt_s.rdat = {20'h0, s_ff.tidx};
				`PRS_A_TVAL: nxt_s.rdat = {20'h0, tbl_ff[s_ff.tidx]};
				`PRS_A_STAT: nxt_s.rdat = {s_ff.krow, 13'h0,
					s_ff.rdy, s_ff.st};
				default: nxt_s.rdat = 32'h0000_0000;
			endcase
		end
		if (acc) begin
			nxt_s.fw = cfw;
			nxt_s.fh = cfh;
			nxt_s.st = PRS_FILL;
			nxt_s.row = cr;
			nxt_s.col = cc + 16'h0001;
			nxt_s.krow = ck;
			nxt_s.ph = cp;
			if (pin.eol) begin
				nxt_s.col = 16'h0000;
				nxt_s.row = cr + 16'h0001;
				if (keep) begin
					nxt_s.krow = ck + 16'h0001;
				end
				nxt_s.ph = (cp + 8'h01 >= s_ff.skip) ? 8'h00 : cp + 8'h01;
				if (s_ff.colr && s_ff.skip == `PRS_FAC_TWO) begin
					nxt_s.ph = 8'h00;
				end
			end
			if (pin.eof) begin
				nxt_s.fh = (nxt_s.krow < cfh) ? nxt_s.krow : cfh;
				nxt_s.orow = 16'h0000;
				nxt_s.ocol = 16'h0000;
				nxt_s.rdy = 1'b0;
				nxt_s.st = PRS_DRAIN;
			end
		end
		if (s_ff.st == PRS_DRAIN) begin
			if (s_ff.fh == 16'h0000 || s_ff.fw == 16'h0000) begin
				nxt_s.st = PRS_IDLE;
				nxt_s.rdy = 1'b1;
			end else begin
				nxt_s.p1.vld = 1'b1;
				nxt_s.p1.data = fbuf_ff[raddr];
				nxt_s.p1.sof = s_ff.orow == 16'h0000 && s_ff.ocol == 16'h0000;
				nxt_s.p1.eol = s_ff.ocol == s_ff.fw - 16'h0001;
				nxt_s.p1.eof = nxt_s.p1.eol &&
					s_ff.orow == s_ff.fh - 16'h0001;
				nxt_s.ocol = s_ff.ocol + 16'h0001;
				if (nxt_s.p1.eol) begin
					nxt_s.ocol = 16'h0000;
					nxt_s.orow = s_ff.orow + 16'h0001;
				end
				if (nxt_s.p1.eof) begin
					nxt_s.st = PRS_IDLE;
					nxt_s.rdy = 1'b1;
				end
			end
		end
		if (s_ff.p1.vld) begin
			nxt_s.out = s_ff.p1;
			nxt_s.out.data = od;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_ff <= '0;
			s_ff.st <= PRS_IDLE;
			s_ff.ten <= `PRS_RST_CTRL; // see R21
			s_ff.fmt <= PRS_FMT12;
			s_ff.skip <= `PRS_FAC_ONE;
			s_ff.vbin <= `PRS_FAC_ONE;
			s_ff.hbin <= `PRS_FAC_ONE;
			s_ff.winw <= MW;
			s_ff.winh <= MH;
			s_ff.rdy <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Table and frame store carry no reset; contents are undefined after it
	always_ff @(posedge core_clk) begin
		if (breq.wr && breq.addr == `PRS_A_TVAL) begin
			tbl_ff[s_ff.tidx] <= breq.wdata[11:0]; // see R13 see R21
		end
		if (wen) begin
			fbuf_ff[waddr] <= din; // see R01
		end
	end

	assign pout = s_ff.out;
	assign rdata = s_ff.rdat;
	assign in_ready = s_ff.rdy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	chk_skip_only_kept: assert property ( // see R01
		wen |-> keep)
		else $error("frame store written for a skipped row");
	chk_skip_even_h: assert property ( // see R03
		breq.wr && breq.addr == `PRS_A_SKIP && breq.wdata[7:0] > 8'h01
		|=> s_ff.winh[0] == 1'b0
		&& s_ff.winh <= $past(s_ff.winh, 1) + 16'h0001)
		else $error("window height not shrunk to even count");
	chk_skip_one_keep: assert property ( // see R07
		breq.wr && breq.addr == `PRS_A_SKIP && breq.wdata[7:0] == 8'h01
		|=> s_ff.winh == $past(s_ff.winh, 1))
		else $error("window height changed on factor one");
	chk_bin_excl: assert property ( // see R05
		breq.wr && breq.addr == `PRS_A_VBIN && breq.wdata[7:0] > 8'h01
		|=> s_ff.skip == `PRS_FAC_ONE ##1 !(s_ff.skip > 8'h01
		&& s_ff.vbin > 8'h01))
		else $error("binning and skipping both active");
	chk_skip_vbin_off: assert property ( // see R05
		breq.wr && breq.addr == `PRS_A_SKIP && breq.wdata[7:0] > 8'h01
		|=> s_ff.vbin == `PRS_FAC_ONE)
		else $error("binning left on after skip write");
	chk_first_row_kept: assert property ( // see R02
		acc && pin.sof |-> keep)
		else $error("first row of frame not kept");
	chk_ready_drain: assert property ( // see R09
		s_ff.st == PRS_DRAIN |-> !s_ff.rdy)
		else $error("pixels accepted while frame drains");
	chk_mir_range: assert property ( // see R08 see R09
		s_ff.st == PRS_DRAIN && s_ff.fw != 16'h0000
		&& s_ff.fh != 16'h0000 |-> rr < s_ff.fh && rc < s_ff.fw)
		else $error("mirrored address outside frame");
	chk_hmir_addr: assert property ( // see R08
		s_ff.st == PRS_DRAIN && s_ff.hmir
		|-> rc + s_ff.ocol == s_ff.fw - 16'h0001)
		else $error("mirrored column address wrong");
	chk_vmir_addr: assert property ( // see R09
		s_ff.st == PRS_DRAIN && s_ff.vmir
		|-> rr + s_ff.orow == s_ff.fh - 16'h0001)
		else $error("mirrored row address wrong");
	chk_bypass_12: assert property ( // see R14
		s_ff.p1.vld && !s_ff.ten && s_ff.fmt == PRS_FMT12
		|=> s_ff.out.vld && s_ff.out.data == $past(s_ff.p1.data, 1))
		else $error("bypass value altered");
	chk_entry_exact: assert property ( // see R15
		s_ff.p1.vld && s_ff.ten && s_ff.fmt == PRS_FMT12
		&& x[2:0] == 3'h0 |=> s_ff.out.data == $past(lo, 1))
		else $error("aligned pixel not taken from its entry");
	chk_top_entry: assert property ( // see R18
		s_ff.p1.vld && s_ff.ten && x >= `PRS_TLAST
		|-> sub == tbl_ff[`PRS_TLAST])
		else $error("top range not held at last entry");
	chk_fmt8_trunc: assert property ( // see R23
		s_ff.p1.vld && s_ff.fmt == PRS_FMT8
		|=> s_ff.out.data[11:8] == 4'h0
		&& s_ff.out.data[7:0] == $past(y[11:4], 1))
		else $error("eight-bit output not truncated");
	chk_fmt10_trunc: assert property ( // see R22
		s_ff.p1.vld && s_ff.fmt == PRS_FMT10
		|=> s_ff.out.data == {2'b00, $past(y[11:2], 1)})
		else $error("ten-bit output not truncated");

	cov_both_mirrors: cover property (
		s_ff.st == PRS_DRAIN && s_ff.hmir && s_ff.vmir ##1 s_ff.p1.eof);
	cov_skip_frame: cover property (
		acc && pin.eof && s_ff.skip > 8'h01);
	cov_interp: cover property (
		s_ff.p1.vld && s_ff.ten && x[2:0] != 3'h0 && !top);
	cov_colour_pairs: cover property (
		acc && pin.eof && s_ff.colr && s_ff.skip == `PRS_FAC_TWO);
endmodule : prs_row_mirror_lut

// ---- prs_consts.svh ----
// Register offsets, field positions and fixed values of the row/mirror stage
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PRS_A_CTRL 8'h00
`define PRS_A_SKIP 8'h04
`define PRS_A_VBIN 8'h08
`define PRS_A_HBIN 8'h0c
`define PRS_A_WINW 8'h10
`define PRS_A_WINH 8'h14
`define PRS_A_TIDX 8'h18
`define PRS_A_TVAL 8'h1c
`define PRS_A_STAT 8'h20
// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define PRS_B_HMIR 0
`define PRS_B_VMIR 1
`define PRS_B_TEN 2
`define PRS_B_COLR 3
`define PRS_B_S10 4
`define PRS_F_FMT 6:5
// ----------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------
`define PRS_FAC_ONE 8'h01
`define PRS_FAC_TWO 8'h02
`define PRS_TSTEP 12'h008
`define PRS_TLAST 12'hff8
`define PRS_WGT_FULL 4'h8
`define PRS_RST_CTRL 1'b0
`endif

// ---- prs_pkg.sv ----
// Types shared by the row skip, mirror and table stage
package prs_pkg;
	typedef enum logic [1:0] {
		PRS_IDLE = 2'b00,
		PRS_FILL = 2'b01,
		PRS_DRAIN = 2'b10
	} prs_st_t;
	typedef enum logic [1:0] {
		PRS_FMT12 = 2'b00,
		PRS_FMT10 = 2'b01,
		PRS_FMT8 = 2'b10
	} prs_fmt_t;
	typedef struct packed {
		logic vld;
		logic sof;
		logic eol;
		logic eof;
		logic [11:0] data;
	} prs_pix_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} prs_breq_t;
	typedef struct packed {
		prs_st_t st;
		logic [31:0] rdat;
		logic hmir;
		logic vmir;
		logic ten;
		logic colr;
		logic s10;
		prs_fmt_t fmt;
		logic [7:0] skip;
		logic [7:0] vbin;
		logic [7:0] hbin;
		logic [15:0] winw;
		logic [15:0] winh;
		logic [11:0] tidx;
		logic [15:0] row;
		logic [15:0] col;
		logic [15:0] krow;
		logic [7:0] ph;
		logic [15:0] fw;
		logic [15:0] fh;
		logic [15:0] orow;
		logic [15:0] ocol;
		prs_pix_t p1;
		prs_pix_t out;
		logic rdy;
	} prs_state_t;
endpackage : prs_pkg

// ---- prs_sensor_model.sv ----
// Sensor readout model that feeds frames into the stage
module prs_sensor_model (
	input wire logic core_clk,
	input wire logic in_ready,
	output prs_pkg::prs_pix_t pin
);
	timeunit 1ns;
	timeprecision 100ps;
	import prs_pkg::*;
	initial pin = '0;
	// Sends w x h pixels valued v + 16*row + col once the stage is ready
	task automatic send(input int w, input int h, input logic [11:0] v);
		logic [11:0] d;
		d = v;
		@(posedge core_clk);
		while (in_ready !== 1'b1) @(posedge core_clk);
		for (int r = 0; r < h; r++) begin
			for (int c = 0; c < w; c++) begin
				d = v + 12'(16 * r + c);
				pin <= '{1'b1, r == 0 && c == 0, c == w - 1,
					c == w - 1 && r == h - 1, d};
				@(posedge core_clk);
			end
		end
		// Idle line shows the inverse of the last pixel, not a held value
		pin <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
	endtask : send
endmodule : prs_sensor_model

// ---- pixel_row_skip_mirror_lut_bench.sv ----
// Self-checking bench of the row skip, mirror and table stage
module pixel_row_skip_mirror_lut_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import prs_pkg::*;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	prs_pix_t pin;
	logic in_ready;
	prs_pix_t pout;
	prs_breq_t breq = '0;
	logic [31:0] rdata;
	logic [14:0] obs [64];
	int nobs = 0;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	typedef struct packed {
		logic [6:0] ctrl;
		logic [11:0] x;
		logic [11:0] y;
	} prs_tb_row_t;
	prs_tb_row_t rows [11] = '{
		'{7'h00, 12'h5a3, 12'h5a3},
		'{7'h04, 12'h008, 12'h010},
		'{7'h04, 12'h00d, 12'h01d},
		'{7'h04, 12'h00c, 12'h01a},
		'{7'h04, 12'hff4, 12'h95e},
		'{7'h04, 12'hfff, 12'habc},
		'{7'h04, 12'hff9, 12'habc},
		'{7'h14, 12'h003, 12'h01a},
		'{7'h24, 12'h00d, 12'h007},
		'{7'h44, 12'hfff, 12'h0ab},
		'{7'h0c, 12'h010, 12'h025}
	};
	prs_row_mirror_lut #(.MAX_W(4), .MAX_H(4)) dut_u (
		.core_clk(core_clk),
		.srst(srst),
		.pin(pin),
		.in_ready(in_ready),
		.pout(pout),
		.breq(breq),
		.rdata(rdata)
	);
	prs_sensor_model prt_u (
		.core_clk(core_clk),
		.in_ready(in_ready),
		.pin(pin)
	);
	always #12.5 core_clk = ~core_clk;
	// Collects output pixels and cuts a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			test_done();
		end
		if (pout.vld === 1'b1 && nobs < 64) begin
			obs[nobs] = {pout.sof, pout.eol, pout.eof, pout.data};
			nobs++;
		end
	end
	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pix(input logic [14:0] got, input logic [14:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_pix
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		breq <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		breq <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		breq <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		breq <= '0;
		#1;
		chk_reg(rdata, exp);
	endtask : rd
	task automatic load(input logic [11:0] idx, input logic [11:0] val);
		wr(8'h18, {20'h0, idx});
		wr(8'h1c, {20'h0, val});
	endtask : load
	task automatic wait_out(input int n);
		for (int k = 0; k < 300 && nobs < n; k++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
		chk_reg(32'(nobs), 32'(n));
	endtask : wait_out
	// Sends a 4 x 4 frame; src maps kept rows to sensor rows
	task automatic frame(input logic [6:0] ctrl, input int fh, input int src[4]);
		int sr;
		int sc;
		wr(8'h00, {25'h0, ctrl});
		nobs = 0;
		prt_u.send(4, 4, 12'h000);
		wait_out(4 * fh);
		for (int k = 0; k < 4 * fh; k++) begin
			sr = src[ctrl[1] ? fh - 1 - k / 4 : k / 4];
			sc = ctrl[0] ? 3 - k % 4 : k % 4;
			chk_pix(obs[k], {k == 0, k % 4 == 3, k == 4 * fh - 1,
				12'(16 * sr + sc)});
		end
	endtask : frame
	task automatic test_done();
		$display("compares %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// ------------------------------------------------
	// Run
	// ------------------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		load(12'd8, 12'h010);
		load(12'd9, 12'hfff);
		load(12'd16, 12'h025);
		load(12'd4080, 12'h800);
		load(12'd4088, 12'habc);
		load(12'd4095, 12'h111);
		wr(8'h18, 32'd8);
		rd(8'h1c, 32'h010);
		wr(8'h10, 32'd1);
		wr(8'h14, 32'd1);
		foreach (rows[i]) begin
			wr(8'h00, {25'h0, rows[i].ctrl});
			nobs = 0;
			prt_u.send(1, 1, rows[i].x);
			wait_out(1);
			chk_pix(obs[0], {3'b111, rows[i].y});
		end
		$display("table rows done");
		wr(8'h10, 32'd4);
		wr(8'h14, 32'd4);
		for (int m = 0; m < 4; m++) frame(7'(m), 4, '{0, 1, 2, 3});
		$display("mirror frames done");
		wr(8'h0c, 32'd2);
		wr(8'h04, 32'd2);
		rd(8'h14, 32'd2);
		frame(7'h00, 2, '{0, 2, 0, 0});
		wr(8'h14, 32'd4);
		wr(8'h04, 32'd2);
		frame(7'h09, 2, '{0, 1, 0, 0});
		wr(8'h04, 32'd1);
		rd(8'h14, 32'd2);
		wr(8'h14, 32'd7);
		wr(8'h04, 32'd3);
		rd(8'h14, 32'd4);
		wr(8'h08, 32'd2);
		rd(8'h04, 32'd1);
		rd(8'h0c, 32'd2);
		wr(8'h04, 32'd2);
		rd(8'h08, 32'd1);
		$display("row skip done");
		wr(8'h24, 32'h5);
		rd(8'h24, 32'h0);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		chk_reg(32'(pout), 32'h0);
		chk_reg(32'(in_ready), 32'h1);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h1);
		rd(8'h08, 32'h1);
		rd(8'h0c, 32'h1);
		rd(8'h10, 32'h4);
		rd(8'h14, 32'h4);
		$display("reset done");
		test_done();
	end
endmodule : pixel_row_skip_mirror_lut_bench
